// *** pbs_status.sv ***
`timescale 1ns/1ps
module pbs_status (
	// Clock and reset
	input  wire  logic        clock,
	input  wire  logic        sys_rst,
	// Management read port
	input  wire  logic [4:0]  reg_addr,
	input  wire  logic        reg_rd,
	output logic [15:0]       reg_rdata,
	// Inputs from sibling registers
	input  wire  logic [15:0] mgmt_options_register,
	input  wire  logic [15:0] link_partner_ability_register,
	// Link, negotiation, fault, jabber and speed conditions
	input  wire  logic        an_enable,
	input  wire  logic        an_done,
	input  wire  logic        far_end_fault,
	input  wire  logic        link_pass,
	input  wire  logic        jabber_seen,
	input  wire  logic        speed_100,
	// Preamble length the management receiver needs
	output logic [5:0]        preamble_bits
);
	import pbs_pkg::*;

	pbs_state_s s_r;
	pbs_state_s s_nxt;
	logic       rd_hit;
	logic       rf_now;
	logic       jab_now;
	logic       pre_on;

	// ------------------------------------------------------------
	// Condition decode
	// ------------------------------------------------------------
	assign rd_hit  = reg_rd && (reg_addr == PBS_ADDR);
	assign rf_now  = link_partner_ability_register[PBS_PARTNER_RF] || far_end_fault;
	assign jab_now = jabber_seen && !speed_100;
	assign pre_on  = mgmt_options_register[PBS_OPT_PRE_BIT];

	// ------------------------------------------------------------
	// Latches, snapshot and preamble length
	// ------------------------------------------------------------
	// Latches update after the read captures data, so no event is lost
	always_comb begin
		s_nxt = s_r;
		// Preamble length is registered so the output comes from a flop
		s_nxt.pre_len = pre_on ? PBS_PRE_SHORT : PBS_PRE_FULL;
		// Remote fault: latched high, a read clears only once cause is gone
		if (rf_now)
			s_nxt.rfault = 1'b1;
		else if (rd_hit)
			s_nxt.rfault = 1'b0;
		// Jabber: same scheme, forced low at 100 Mb/s
		if (speed_100)
			s_nxt.jabber = 1'b0;
		else if (jab_now)
			s_nxt.jabber = 1'b1;
		else if (rd_hit)
			s_nxt.jabber = 1'b0;
		// Link: a failure holds low until read, then follows link pass
		if (!link_pass)
			s_nxt.link = 1'b0;
		else if (rd_hit || s_r.link)
			s_nxt.link = 1'b1;
		// Read data captured from the pre-update latch values
		if (rd_hit) begin
			s_nxt.rdata[PBS_BIT_T4]           = 1'b0;
			s_nxt.rdata[14:11]                = PBS_ABILITY;
			s_nxt.rdata[10:7]                 = PBS_UNUSED;
			s_nxt.rdata[PBS_BIT_PRE]          = pre_on;
			s_nxt.rdata[PBS_BIT_ANDONE]       = an_enable && an_done;
			s_nxt.rdata[PBS_BIT_RFAULT]       = s_r.rfault || rf_now;
			s_nxt.rdata[PBS_BIT_ANABL]        = 1'b1;
			s_nxt.rdata[PBS_BIT_LINK]         = s_r.link;
			s_nxt.rdata[PBS_BIT_JABBER]       = (s_r.jabber || jab_now) && !speed_100;
			s_nxt.rdata[PBS_BIT_EXT]          = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Link resets low so the first read shows 0
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_r.rdata  <= PBS_RESET_VALUE;
			s_r.rfault <= 1'b0;
			s_r.link   <= 1'b0;
			s_r.jabber <= 1'b0;
			s_r.pre_len <= PBS_PRE_SHORT; // Matches the mirrored bit's default
		end else begin
			s_r <= s_nxt;
		end
	end

	// Both outputs come straight from flops
	assign reg_rdata     = s_r.rdata;
	assign preamble_bits = s_r.pre_len;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_FIXED_BITS: assert property (@(posedge clock) disable iff (sys_rst)
		$past(rd_hit) |-> reg_rdata[15:7] == 9'h0F0)
		else $error("fixed status bits wrong");
	AST_FIXED_LOW: assert property (@(posedge clock) disable iff (sys_rst)
		$past(rd_hit) |-> reg_rdata[3] && reg_rdata[0])
		else $error("ability bits not set");
	AST_PRE_MIRROR: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit |=> reg_rdata[6] == $past(pre_on))
		else $error("preamble bit not mirrored");
	AST_PRE_LEN: assert property (@(posedge clock) disable iff (sys_rst)
		1'b1 |=> preamble_bits == ($past(pre_on) ? 6'h02 : 6'h20))
		else $error("preamble length wrong");
	AST_AN_OFF: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && !an_enable |=> !reg_rdata[5])
		else $error("an complete with an disabled");
	AST_RF_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		rf_now ##1 !rd_hit |=> s_r.rfault)
		else $error("remote fault dropped without read");
	AST_RF_READ: assert property (@(posedge clock) disable iff (sys_rst)
		rf_now ##1 rd_hit |=> reg_rdata[4])
		else $error("remote fault lost on read");
	AST_LINK_LATCH: assert property (@(posedge clock) disable iff (sys_rst)
		!link_pass ##1 (link_pass && !rd_hit) [*2] |=> !s_r.link)
		else $error("link rose without read");
	AST_LINK_READ: assert property (@(posedge clock) disable iff (sys_rst)
		!s_r.link && rd_hit |=> !reg_rdata[2])
		else $error("link read not latched value");
	AST_JAB_100: assert property (@(posedge clock) disable iff (sys_rst)
		speed_100 |=> !s_r.jabber)
		else $error("jabber set at 100");
	AST_JAB_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.jabber && !rd_hit && !speed_100 |=> s_r.jabber)
		else $error("jabber cleared without read");

	// ------------------------------------------------------------
	// Field checks
	// ------------------------------------------------------------
	// Reset loads the idle word and clears every latch
	AST_RESET_VAL: assert property (@(posedge clock)
		sys_rst |=> reg_rdata == PBS_RESET_VALUE && !s_r.link && !s_r.rfault && !s_r.jabber)
		else $error("reset state wrong");
	// Four-pair ability never advertised
	AST_T4_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
		$past(rd_hit) |-> !reg_rdata[PBS_BIT_T4])
		else $error("four-pair bit set");
	// Unused field stays clear in every snapshot
	AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
		$past(rd_hit) |-> reg_rdata[10:7] == PBS_UNUSED)
		else $error("unused bits not zero");
	// Negotiation ability always reported
	AST_ANABL_BIT: assert property (@(posedge clock) disable iff (sys_rst)
		$past(rd_hit) |-> reg_rdata[PBS_BIT_ANABL])
		else $error("negotiation ability bit clear");

	// Completion shows when negotiation is enabled and done
	AST_AN_DONE: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && an_enable && an_done |=> reg_rdata[PBS_BIT_ANDONE])
		else $error("an complete not reported");
	// No completion before negotiation has finished
	AST_AN_WAIT: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && !an_done |=> !reg_rdata[PBS_BIT_ANDONE])
		else $error("an complete reported early");

	// Any fault cause sets the latch on the next edge
	AST_RF_SET: assert property (@(posedge clock) disable iff (sys_rst)
		rf_now |=> s_r.rfault)
		else $error("remote fault not latched");
	// A read clears the latch once the cause has gone
	AST_RF_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.rfault && rd_hit && !rf_now |=> !s_r.rfault)
		else $error("remote fault not cleared by read");
	// A read with the cause still present keeps the latch
	AST_RF_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && rf_now |=> s_r.rfault)
		else $error("remote fault cleared while present");
	// A live fault is reported by the read that meets it
	AST_RF_READ_LIVE: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && rf_now |=> reg_rdata[PBS_BIT_RFAULT])
		else $error("live remote fault not reported");

	// Link loss drops the latch on the next edge
	AST_LINK_DROP: assert property (@(posedge clock) disable iff (sys_rst)
		!link_pass |=> !s_r.link)
		else $error("link latch kept after failure");
	// A read while in link pass raises the latch again
	AST_LINK_RISE: assert property (@(posedge clock) disable iff (sys_rst)
		link_pass && rd_hit |=> s_r.link)
		else $error("link latch not raised by read");
	// An established link stays reported
	AST_LINK_KEEP: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.link && link_pass |=> s_r.link)
		else $error("link latch dropped while link pass");
	// A read of an established link returns 1
	AST_LINK_UP_READ: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.link && rd_hit |=> reg_rdata[PBS_BIT_LINK])
		else $error("link up not reported");

	// Jabber at 10 Mb/s sets the latch
	AST_JAB_SET: assert property (@(posedge clock) disable iff (sys_rst)
		jabber_seen && !speed_100 |=> s_r.jabber)
		else $error("jabber not latched");
	// A read clears the latch once jabber has ended
	AST_JAB_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.jabber && rd_hit && !jabber_seen |=> !s_r.jabber)
		else $error("jabber not cleared by read");
	// A latched jabber is reported by the next read
	AST_JAB_READ: assert property (@(posedge clock) disable iff (sys_rst)
		s_r.jabber && rd_hit && !speed_100 |=> reg_rdata[PBS_BIT_JABBER])
		else $error("jabber read lost");
	// At 100 Mb/s a read never shows jabber
	AST_JAB_READ_100: assert property (@(posedge clock) disable iff (sys_rst)
		rd_hit && speed_100 |=> !reg_rdata[PBS_BIT_JABBER])
		else $error("jabber read at 100");

	// Read data holds between reads of this register
	AST_HOLD_DATA: assert property (@(posedge clock) disable iff (sys_rst)
		!rd_hit |=> $stable(reg_rdata))
		else $error("read data changed without read");
	// Reads of other addresses leave the word alone
	AST_RD_OTHER: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr != PBS_ADDR |=> $stable(reg_rdata))
		else $error("other address refreshed word");
endmodule

// *** pbs_pkg.sv ***
package pbs_pkg;
	localparam logic [4:0]  PBS_ADDR        = 5'h01;
	localparam int          PBS_BIT_T4      = 15;
	localparam int          PBS_BIT_PRE     = 6;
	localparam int          PBS_BIT_ANDONE  = 5;
	localparam int          PBS_BIT_RFAULT  = 4;
	localparam int          PBS_BIT_ANABL   = 3;
	localparam int          PBS_BIT_LINK    = 2;
	localparam int          PBS_BIT_JABBER  = 1;
	localparam int          PBS_BIT_EXT     = 0;
	localparam int          PBS_OPT_PRE_BIT = 1;
	localparam int          PBS_PARTNER_RF  = 13;
	localparam logic [3:0]  PBS_ABILITY     = 4'hF;
	localparam logic [3:0]  PBS_UNUSED      = 4'h0;
	localparam logic [5:0]  PBS_PRE_FULL    = 6'h20;
	localparam logic [5:0]  PBS_PRE_SHORT   = 6'h02;
	localparam logic [15:0] PBS_RESET_VALUE = 16'h7849;
	typedef struct packed {
		logic [15:0] rdata;
		logic        rfault;
		logic        link;
		logic        jabber;
		logic [5:0]  pre_len;
	} pbs_state_s;
endpackage

// *** pbs_mgmt_model.sv ***
`timescale 1ns/1ps
module pbs_mgmt_model (
	// Clock
	input  wire logic        clock,
	// Management read port
	output logic [4:0]       reg_addr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata
);
	// Idle bus before the first read
	initial begin
		reg_addr = 5'h1F;
		reg_rd   = 1'b0;
	end
	// One-cycle strobe, data taken at the edge after the answer
	task automatic do_read(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd   <= 1'b0;
		reg_addr <= ~a; // Released address must not keep its old value
		// Word stands from the answering edge on, so it is settled here
		@(posedge clock);
		d = reg_rdata;
	endtask
endmodule

// *** tb_phy_basic_status_register.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h, expected %h", $time, g, e); end end
module tb_phy_basic_status_register;
	import pbs_pkg::*;
	logic        clock = 1'b0, sys_rst = 1'b1, an_enable = 1'b0, an_done = 1'b0, far_end_fault = 1'b0;
	logic        link_pass = 1'b0, jabber_seen = 1'b0, speed_100 = 1'b0, reg_rd;
	logic [4:0]  reg_addr;
	logic [5:0]  preamble_bits;
	logic [15:0] reg_rdata, d, mgmt_options_register = 16'h0002;
	logic [15:0] link_partner_ability_register = 16'h0000;
	int          n_errors = 0, checks = 0;
	// ----------------------------------------
	// Clock, design and controller
	// ----------------------------------------
	always #50 clock = ~clock;
	pbs_status i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mgmt_options_register(mgmt_options_register),
		.link_partner_ability_register(link_partner_ability_register), .an_enable(an_enable),
		.an_done(an_done), .far_end_fault(far_end_fault), .link_pass(link_pass),
		.jabber_seen(jabber_seen), .speed_100(speed_100), .preamble_bits(preamble_bits));
	pbs_mgmt_model i_mgr (.clock(clock), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Expected word: fixed bits built from the bit map, live fields as arguments
	function automatic logic [15:0] st(input int p, a, r, l, j);
		return {1'b0, 4'hF, 4'h0, p[0], a[0], r[0], 1'b1, l[0], j[0], 1'b1};
	endfunction
	task automatic rd(input logic [15:0] e);
		i_mgr.do_read(5'h01, d);
		`CHK(d, e)
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the roughly 70 cycles the tests need
	initial begin
		#(2000 * 100);
		n_errors++;
		give_verdict;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rd(st(1, 0, 0, 0, 0));
		`CHK(preamble_bits, 6'h02)
		@(posedge clock) mgmt_options_register <= 16'h0000;
		rd(st(0, 0, 0, 0, 0));
		`CHK(preamble_bits, 6'h20)
		// Mirror flips, but a read of another address must not refresh the word
		@(posedge clock) mgmt_options_register <= 16'h0002;
		i_mgr.do_read(5'h02, d);
		`CHK(reg_rdata, st(0, 0, 0, 0, 0))
		@(posedge clock) begin
			an_enable <= 1'b1;
			an_done   <= 1'b1;
			mgmt_options_register <= 16'h0000;
		end
		rd(st(0, 1, 0, 0, 0));
		@(posedge clock) an_enable <= 1'b0;
		rd(st(0, 0, 0, 0, 0));
		@(posedge clock) link_pass <= 1'b1;
		rd(st(0, 0, 0, 0, 0));
		rd(st(0, 0, 0, 1, 0));
		@(posedge clock) link_pass <= 1'b0;
		@(posedge clock) link_pass <= 1'b1;
		rd(st(0, 0, 0, 0, 0));
		rd(st(0, 0, 0, 1, 0));
		// One-cycle partner fault must not be lost
		@(posedge clock) link_partner_ability_register <= 16'h2000;
		@(posedge clock) link_partner_ability_register <= 16'h0000;
		rd(st(0, 0, 1, 1, 0));
		rd(st(0, 0, 0, 1, 0));
		@(posedge clock) far_end_fault <= 1'b1;
		rd(st(0, 0, 1, 1, 0));
		@(posedge clock) far_end_fault <= 1'b0;
		rd(st(0, 0, 1, 1, 0));
		rd(st(0, 0, 0, 1, 0));
		@(posedge clock) jabber_seen <= 1'b1;
		@(posedge clock) jabber_seen <= 1'b0;
		rd(st(0, 0, 0, 1, 1));
		rd(st(0, 0, 0, 1, 0));
		// A jabber latched at 10 Mb/s is forced away by the speed change
		@(posedge clock) jabber_seen <= 1'b1;
		@(posedge clock) speed_100 <= 1'b1;
		rd(st(0, 0, 0, 1, 0));
		give_verdict;
	end
endmodule
